// *** rtl/rch_handler.sv ***
// Purpose: Remote command handler of a powerline node.
// Assumes: Packet layer hands over decoded commands one cycle each.
// Notes:   Status bits are sticky; a set beats a clear in one cycle.
//
// Contract
// R1: Outgoing code comes from host register; received code is stored.
// R2: Control codes 01-08, 0C-0F processed locally when unlocked, replied.
// R3: Codes 09/0A acked only when acked service; host told of data.
// R4: No ack within 500 ms reports a no-ack condition.
// R5: Answer 0B within 1.5 s reports success, else no-response.
// R6: Every outcome updates status, including the change flag.
// R7: Codes 30-FF pass to the host as user commands.
// R8: Code 01 changes only the transmit-enable bit of the mode register.
// R9: Set commands reply 00 when unlocked, 01 when locked.
// R10: Code 03 turns wide addressing on or off.
// R11: Code 04 loads an 8-bit or 16-bit node address.
// R12: Codes 05/06 return address or unique id, only if transmit enabled.
// R13: Codes 07/08 return mode or revision, only if transmit enabled.
// R14: Remote host must send its answer within 1.5 s of a request.
// R15: Code 0C payload 0 enables band detection, 1 disables it.
// R16: Code 0D loads the 3-bit detection threshold.
// R17: Code 0E writes single and multiple group bytes; 0F returns them.
// R18: Group addressing forces unacknowledged service.
// R19: Codes 10-2F are ignored and not forwarded.
`timescale 1ns/1ps
`include "rch_regs.svh"
module rch_handler #(
  parameter int ACK_CYCLES  = `RCH_ACK_CYCLES,
  parameter int RESP_CYCLES = `RCH_RESP_CYCLES,
  parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF, // Arbitrary.
  parameter logic [7:0]  REVISION  = 8'h10                 // Arbitrary.
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Host control
  input  wire logic             cfgLock,
  input  wire logic [7:0]       outgoingCommandCode,
  input  wire logic             hostSend,
  input  wire logic             hostAckService,
  input  wire logic             hostGroupAddr,
  input  wire logic             statusClear,
  // Received command from the packet layer
  input  wire logic             rxValid,
  input  wire logic [7:0]       rxCode,
  input  wire logic [15:0]      rxPayload,
  input  wire logic             rxIsAck,
  // Ack line from the remote node pin
  input  wire logic             ackPin,
  // Transmit request to the packet layer
  output logic                  txValid,
  output logic [7:0]            txCode,
  output logic                  txAckService,
  output logic                  txIsReply,
  output logic [63:0]           txPayload,
  output logic [3:0]            txPayloadLen,
  // Node state
  output logic [7:0]            nodeModeReg,
  output logic                  wideAddr,
  output logic [15:0]           nodeAddr,
  output logic                  bandDetectEn,
  output logic [2:0]            detectThreshold,
  output logic [7:0]            singleGroup,
  output logic [7:0]            multiGroup,
  // Host status
  output logic [7:0]            incomingCommandCode,
  output rch_pkg::rch_stat_t    intStatus,
  output logic                  statusValueChange
);
  import rch_pkg::*;

  typedef struct packed {
    logic        txValid;
    logic [7:0]  txCode;
    logic        txAckService;
    logic        txIsReply;
    logic [63:0] txPayload;
    logic [3:0]  txPayloadLen;
    logic [7:0]  mode;
    logic        wide;
    logic [15:0] addr;
    logic        band;
    logic [2:0]  thresh;
    logic        [7:0] sgrp;
    logic        [7:0] mgrp;
    logic [7:0]  rxCodeHeld;
    rch_stat_t   status;
    logic        change;
    logic        waitAck;
    logic        waitResp;
  } rch_st_t;

  rch_st_t     stateReg;
  rch_st_t     stateNext;
  rch_tmr_if   ackTmr();
  rch_tmr_if   respTmr();
  logic        ackSeen;
  logic        ackSeenDly;
  logic        ackEdge;

  // A pin from another node is synchronised before use.
  rch_sync3 u_ack_sync (
    .clk  (clk),
    .rst_n(rst_n),
    .din  (ackPin),
    .dout (ackSeen)
  );

  // R4 ack timer
  rch_timeout #(.CYCLES(ACK_CYCLES)) u_ack_tmr (
    .clk  (clk),
    .rst_n(rst_n),
    .tmr  (ackTmr.tmr)
  );

  // R5 response timer
  rch_timeout #(.CYCLES(RESP_CYCLES)) u_resp_tmr (
    .clk  (clk),
    .rst_n(rst_n),
    .tmr  (respTmr.tmr)
  );

  // Rising edge of the synchronised ack, taken from the clean stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ackSeenDly <= 1'b0;
    else
      ackSeenDly <= ackSeen;
  end
  assign ackEdge = ackSeen & ~ackSeenDly;

  // Next-state logic for the whole handler.
  always_comb
  begin
    logic        gotAck;
    logic        isCtrl;
    logic [7:0]  setFlags;
    gotAck   = 1'b0;
    isCtrl   = 1'b0;
    setFlags = 8'h00;
    stateNext = stateReg;
    stateNext.txValid = 1'b0;
    ackTmr.start  = 1'b0;
    ackTmr.stop   = 1'b0;
    respTmr.start = 1'b0;
    respTmr.stop  = 1'b0;

    // R1 outgoing code
    if (hostSend && !stateReg.txValid)
    begin
      stateNext.txValid = 1'b1;
      stateNext.txCode  = outgoingCommandCode;
      stateNext.txIsReply = 1'b0;
      stateNext.txPayload = 64'h0000000000000000;
      stateNext.txPayloadLen = 4'h0;
      // R18 group forces unacked
      stateNext.txAckService = hostAckService & ~hostGroupAddr;
      if (hostAckService && !hostGroupAddr)
      begin
        ackTmr.start = 1'b1;
        stateNext.waitAck = 1'b1;
      end
      // R5 start response wait
      if (outgoingCommandCode == `RCH_CMD_ASK)
      begin
        respTmr.start = 1'b1;
        stateNext.waitResp = 1'b1;
      end
    end

    gotAck = ackEdge | (rxValid & rxIsAck);
    // R4 ack received
    if (stateReg.waitAck && gotAck)
    begin
      ackTmr.stop = 1'b1;
      stateNext.waitAck = 1'b0;
      setFlags[RCH_ST_OK] = 1'b1;
    end
    // R4 no-ack report
    if (ackTmr.expired && stateReg.waitAck)
    begin
      stateNext.waitAck = 1'b0;
      setFlags[RCH_ST_NO_ACK] = 1'b1;
    end
    // R5 no-response report
    if (respTmr.expired && stateReg.waitResp)
    begin
      stateNext.waitResp = 1'b0;
      setFlags[RCH_ST_NO_RESP] = 1'b1;
    end

    if (rxValid && !rxIsAck)
    begin
      // R1 store received code
      stateNext.rxCodeHeld = rxCode;
      isCtrl = (rxCode >= `RCH_CMD_TX_EN && rxCode <= `RCH_CMD_GET_REV)
            || (rxCode >= `RCH_CMD_BAND && rxCode <= `RCH_CMD_GET_GRP);
      stateNext.txIsReply = 1'b1;
      stateNext.txAckService = 1'b0;
      stateNext.txCode = rxCode;
      stateNext.txPayload = 64'h0000000000000000;
      stateNext.txPayloadLen = 4'h1;
      if (isCtrl)
      begin
        // R2 local processing
        setFlags[RCH_ST_RX_CTRL] = 1'b1;
        case (rxCode)
          `RCH_CMD_GET_ADDR:
          begin
            // R12 address read
            stateNext.txValid = stateReg.mode[`RCH_MODE_TXEN_BIT];
            stateNext.txPayload = {48'h0, stateReg.addr};
            stateNext.txPayloadLen = stateReg.wide ? 4'h2 : 4'h1;
          end
          `RCH_CMD_GET_UID:
          begin
            // R12 unique id read
            stateNext.txValid = stateReg.mode[`RCH_MODE_TXEN_BIT];
            stateNext.txPayload = UNIQUE_ID;
            stateNext.txPayloadLen = 4'h8;
          end
          `RCH_CMD_GET_MODE:
          begin
            // R13 mode read
            stateNext.txValid = stateReg.mode[`RCH_MODE_TXEN_BIT];
            stateNext.txPayload = {56'h0, stateReg.mode};
          end
          `RCH_CMD_GET_REV:
          begin
            // R13 revision read
            stateNext.txValid = stateReg.mode[`RCH_MODE_TXEN_BIT];
            stateNext.txPayload = {56'h0, REVISION};
          end
          `RCH_CMD_GET_GRP:
          begin
            // R17 group read
            stateNext.txValid = stateReg.mode[`RCH_MODE_TXEN_BIT];
            stateNext.txPayload = {48'h0, stateReg.mgrp, stateReg.sgrp};
            stateNext.txPayloadLen = 4'h2;
          end
          default:
          begin
            // R9 set reply code
            stateNext.txValid = 1'b1;
            stateNext.txPayload = cfgLock ? {56'h0, `RCH_REPLY_DENIED}
                                          : {56'h0, `RCH_REPLY_OK};
            if (cfgLock)
              setFlags[RCH_ST_DENIED] = 1'b1;
            else
            begin
              case (rxCode)
                // R8 only transmit-enable bit
                `RCH_CMD_TX_EN:
                  stateNext.mode[`RCH_MODE_TXEN_BIT] = rxPayload[0];
                // R10 wide addressing
                `RCH_CMD_WIDE:
                  stateNext.wide = rxPayload[0];
                // R11 address load
                `RCH_CMD_SET_ADDR:
                  stateNext.addr = stateReg.wide ? rxPayload
                                                 : {8'h00, rxPayload[7:0]};
                // R15 band detect, inverted
                `RCH_CMD_BAND:
                  stateNext.band = ~rxPayload[0];
                // R16 threshold load
                `RCH_CMD_THRESH:
                  stateNext.thresh = rxPayload[2:0];
                // R17 group write
                `RCH_CMD_SET_GRP:
                begin
                  stateNext.sgrp = rxPayload[7:0];
                  stateNext.mgrp = rxPayload[15:8];
                end
                default:
                  stateNext.thresh = stateReg.thresh;
              endcase
            end
          end
        endcase
      end
      else if (rxCode == `RCH_CMD_PUSH || rxCode == `RCH_CMD_ASK)
      begin
        // R3 ack only when acked
        stateNext.txValid = hostAckService & ~hostGroupAddr;
        stateNext.txPayloadLen = 4'h0;
        setFlags[RCH_ST_RX_DATA] = 1'b1;
      end
      else if (rxCode == `RCH_CMD_ANSWER)
      begin
        // R5 answer within window
        setFlags[RCH_ST_RX_DATA] = 1'b1;
        if (stateReg.waitResp)
        begin
          respTmr.stop = 1'b1;
          stateNext.waitResp = 1'b0;
          setFlags[RCH_ST_RESP_OK] = 1'b1;
        end
      end
      else if (rxCode >= `RCH_CMD_USER_LO)
        // R7 user commands to host
        setFlags[RCH_ST_RX_USER] = 1'b1;
      // R19 reserved codes set no status and send no reply; their code is still held.
    end

    // R6 status update, set wins
    if (statusClear)
    begin
      stateNext.status = 8'h00;
      stateNext.change = 1'b0;
    end
    stateNext.status = stateNext.status | setFlags;
    if (setFlags != 8'h00)
      stateNext.change = 1'b1;
  end

  // Register stage; mode, threshold and address reset values come from the header, band detect resets to 1.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= '0;
      stateReg.mode <= `RCH_MODE_RESET;
      stateReg.thresh <= `RCH_THRESH_RESET;
      stateReg.addr <= `RCH_ADDR_RESET;
      stateReg.band <= 1'b1;
    end
    else
      stateReg <= stateNext;
  end

  // Outputs straight from the state register.
  assign txValid             = stateReg.txValid;
  assign txCode              = stateReg.txCode;
  assign txAckService        = stateReg.txAckService;
  assign txIsReply           = stateReg.txIsReply;
  assign txPayload           = stateReg.txPayload;
  assign txPayloadLen        = stateReg.txPayloadLen;
  assign nodeModeReg         = stateReg.mode;
  assign wideAddr            = stateReg.wide;
  assign nodeAddr            = stateReg.addr;
  assign bandDetectEn        = stateReg.band;
  assign detectThreshold     = stateReg.thresh;
  assign singleGroup         = stateReg.sgrp;
  assign multiGroup          = stateReg.mgrp;
  assign incomingCommandCode = stateReg.rxCodeHeld;
  assign intStatus           = stateReg.status;
  assign statusValueChange   = stateReg.change;
endmodule

// *** include/rch_regs.svh ***
// Purpose: Constants for the remote command handler.
// Assumes: 20 MHz clock.
// Notes:   Timing counts derive from times printed in milliseconds.
`ifndef RCH_REGS_SVH
`define RCH_REGS_SVH
`define RCH_CLK_HZ        20000000
`define RCH_ACK_WAIT_MS   500
`define RCH_RESP_WAIT_MS  1500
`define RCH_ACK_CYCLES    ((`RCH_CLK_HZ / 1000) * `RCH_ACK_WAIT_MS)
`define RCH_RESP_CYCLES   ((`RCH_CLK_HZ / 1000) * `RCH_RESP_WAIT_MS)
`define RCH_CMD_TX_EN     8'h01
`define RCH_CMD_WIDE      8'h03
`define RCH_CMD_SET_ADDR  8'h04
`define RCH_CMD_GET_ADDR  8'h05
`define RCH_CMD_GET_UID   8'h06
`define RCH_CMD_GET_MODE  8'h07
`define RCH_CMD_GET_REV   8'h08
`define RCH_CMD_PUSH      8'h09
`define RCH_CMD_ASK       8'h0A
`define RCH_CMD_ANSWER    8'h0B
`define RCH_CMD_BAND      8'h0C
`define RCH_CMD_THRESH    8'h0D
`define RCH_CMD_SET_GRP   8'h0E
`define RCH_CMD_GET_GRP   8'h0F
`define RCH_CMD_USER_LO   8'h30
`define RCH_REPLY_OK      8'h00
`define RCH_REPLY_DENIED  8'h01
`define RCH_MODE_TXEN_BIT 7
`define RCH_MODE_RESET    8'h00
`define RCH_THRESH_RESET  3'h0
`define RCH_ADDR_RESET    16'h0000
`endif

// *** include/rch_pkg.sv ***
// Purpose: Types for the remote command handler.
// Assumes: Nothing beyond the constants header.
// Notes:   Status bits form one sticky vector.
package rch_pkg;
  typedef enum logic [2:0] {
    RCH_ST_OK, RCH_ST_NO_ACK, RCH_ST_NO_RESP, RCH_ST_RESP_OK,
    RCH_ST_RX_CTRL, RCH_ST_RX_DATA, RCH_ST_RX_USER, RCH_ST_DENIED
  } rch_stat_idx_t;
  typedef logic [7:0] rch_stat_t;
endpackage

// *** include/rch_tmr_if.sv ***
// Purpose: Start, stop and expiry between handler and a timeout counter.
// Assumes: One clock shared by both ends.
// Notes:   Start restarts a running count.
`timescale 1ns/1ps
interface rch_tmr_if;
  logic start;
  logic stop;
  logic expired;
  logic running;
  modport ctl (output start, output stop, input expired, input running);
  modport tmr (input start, input stop, output expired, output running);
endinterface

// *** rtl/rch_timeout.sv ***
// Purpose: Single-shot timeout counter.
// Assumes: Count fits in the counter width.
// Notes:   Expiry is a one-cycle pulse and ends the run.
`timescale 1ns/1ps
module rch_timeout #(
  parameter int CYCLES = 10000000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  rch_tmr_if.tmr   tmr
);
  import rch_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        exp;
  } rch_tmr_st_t;
  rch_tmr_st_t stateReg;
  rch_tmr_st_t stateNext;

  // A stop wins over expiry in the same cycle; a start wins over both.
  always_comb
  begin
    stateNext = stateReg;
    stateNext.exp = 1'b0;
    if (tmr.start)
    begin
      stateNext.run = 1'b1;
      stateNext.cnt = 32'(CYCLES - 1);
    end
    else if (tmr.stop)
      stateNext.run = 1'b0;
    else if (stateReg.run)
    begin
      if (stateReg.cnt == 32'h00000000)
      begin
        stateNext.run = 1'b0;
        stateNext.exp = 1'b1;
      end
      else
        stateNext.cnt = stateReg.cnt - 32'h00000001;
    end
  end

  // Register stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end

  assign tmr.expired = stateReg.exp;
  assign tmr.running = stateReg.run;
endmodule

// *** rtl/rch_sync3.sv ***
// Purpose: Three-stage synchroniser for a pin level.
// Assumes: Input is asynchronous to clk.
// Notes:   Output moves only when stages two and three agree.
`timescale 1ns/1ps
module rch_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Level
  input  wire logic din,
  output logic      dout
);
  import rch_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } rch_sync_st_t;
  rch_sync_st_t stateReg;
  rch_sync_st_t stateNext;

  // The first stage feeds only the second, to contain metastability.
  always_comb
  begin
    stateNext = stateReg;
    stateNext.s1 = din;
    stateNext.s2 = stateReg.s1;
    stateNext.s3 = stateReg.s2;
    if (stateReg.s2 == stateReg.s3)
      stateNext.q = stateReg.s3;
  end

  // Register stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stateReg <= '0;
    else
      stateReg <= stateNext;
  end

  assign dout = stateReg.q;
endmodule

// *** testbench/rch_handler_chk.sv ***
// Purpose: Port-level checks of the remote command handler.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes:   Timeout lengths are judged by the bench, not here.
`timescale 1ns/1ps
module rch_handler_chk (
  // Clock and reset
  input wire logic               clk,
  input wire logic               rst_n,
  // Host side
  input wire logic               cfgLock,
  input wire logic               hostSend,
  input wire logic [7:0]         outgoingCommandCode,
  input wire logic               hostGroupAddr,
  // Received command
  input wire logic               rxValid,
  input wire logic [7:0]         rxCode,
  input wire logic [15:0]        rxPayload,
  input wire logic               rxIsAck,
  // Transmit and state
  input wire logic               txValid,
  input wire logic [7:0]         txCode,
  input wire logic               txAckService,
  input wire logic               txIsReply,
  input wire logic [63:0]        txPayload,
  input wire logic [7:0]         nodeModeReg,
  input wire logic [2:0]         detectThreshold,
  input wire logic [7:0]         incomingCommandCode,
  input wire rch_pkg::rch_stat_t intStatus,
  input wire logic               statusValueChange
);
  import rch_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic rxCmd;
  logic setCode;
  logic getCode;
  // Acks carry no code, so they never count as commands.
  assign rxCmd = rxValid && !rxIsAck;
  assign setCode = rxCmd && (rxCode inside {8'h01, 8'h03, 8'h04, 8'h0C,
                                            8'h0D, 8'h0E});
  assign getCode = rxCmd && (rxCode inside {[8'h05:8'h08], 8'h0F});
  deny_locked_a: assert property (setCode && cfgLock |=>
    txValid && txIsReply && txPayload[7:0] == 8'h01 &&
    $stable(nodeModeReg) && $stable(detectThreshold))
    else $error("locked set not denied");
  reply_ok_a: assert property (setCode && !cfgLock |=>
    txValid && txIsReply && txPayload[7:0] == 8'h00 && intStatus[4])
    else $error("unlocked set not answered");
  txen_only_a: assert property (
    setCode && !cfgLock && rxCode == 8'h01 |=>
    nodeModeReg == {$past(rxPayload[0]), $past(nodeModeReg[6:0])})
    else $error("mode register update wrong");
  thresh_load_a: assert property (
    setCode && !cfgLock && rxCode == 8'h0D |=>
    detectThreshold == $past(rxPayload[2:0]))
    else $error("threshold not loaded");
  get_silent_a: assert property (getCode && !nodeModeReg[7] && !hostSend
    |=> !txValid)
    else $error("get answered while transmit disabled");
  reserved_drop_a: assert property (rxCmd && !hostSend &&
    (rxCode inside {[8'h10:8'h2F]}) |=> !txValid && !$rose(intStatus[6]))
    else $error("reserved code acted on");
  user_pass_a: assert property (rxCmd && rxCode >= 8'h30 |=>
    intStatus[6] && incomingCommandCode == $past(rxCode))
    else $error("user code not forwarded");
  send_code_a: assert property (hostSend && !txValid && !rxValid |=>
    txValid && !txIsReply && txCode == $past(outgoingCommandCode))
    else $error("host command not sent");
  group_unack_a: assert property (hostSend && !txValid && !rxValid &&
    hostGroupAddr |=> !txAckService)
    else $error("group send acknowledged");
  change_flag_a: assert property (|(intStatus & ~$past(intStatus)) |->
    statusValueChange)
    else $error("change flag missing");
endmodule

// *** testbench/rch_peer_model.sv ***
// Purpose: Far node that answers acknowledged traffic on the ack line.
// Assumes: Ack line idles low through its pull-down.
// Notes:   The pulse lasts four cycles so the synchroniser sees it.
`timescale 1ns/1ps
module rch_peer_model #(
  parameter int DELAY = 6
) (
  // Clock and control
  input wire logic clk,
  input wire logic ackEnable,
  // Transmit request seen on the line
  input wire logic txValid,
  input wire logic txAckService,
  input wire logic txIsReply,
  // Ack line
  output logic     ackPin
);
  int cnt = 0;
  initial ackPin = 1'b0;
  // Counts down the turnaround, then pulses; a silent peer never answers.
  always @(negedge clk)
  begin
    if (txValid && txAckService && !txIsReply && ackEnable)
      cnt <= DELAY + 4;
    else if (cnt > 0)
      cnt <= cnt - 1;
    ackPin <= (cnt inside {[1:4]});
  end
endmodule

// *** testbench/rch_handler_test.sv ***
// Purpose: Sequence tests of the remote command handler.
// Assumes: Short timeouts of 20 and 60 cycles stand in for the real ones.
// Notes:   Inputs change on the falling edge only.
`timescale 1ns/1ps
module rch_handler_test;
  import rch_pkg::*;
  localparam int ACKN = 20;
  localparam int RESPN = 60;
  localparam logic [63:0] UID = 64'hA1B2C3D4E5F60718; // Arbitrary.
  localparam logic [7:0]  REV = 8'h2C;                // Arbitrary.
  logic clk = 0, rst_n = 0, cfgLock = 0, hostSend = 0, hostAck = 0;
  logic hostGroupAddr = 0, statusClear = 0, rxValid = 0, rxIsAck = 0;
  logic ackPin, ackEnable = 0, txValid, txAckService, txIsReply;
  logic wideAddr, bandDetectEn, statusValueChange;
  logic [7:0] outCode = 0, rxCode = 0, txCode, nodeModeReg, single, multi;
  logic [7:0] inCode;
  logic [15:0] rxPayload = 0, nodeAddr;
  logic [63:0] txPayload;
  logic [3:0] txPayloadLen;
  logic [2:0] thresh;
  rch_stat_t intStatus;
  int nMismatch = 0, nChecks = 0, cyc = 0;
  logic [7:0] gc [4] = '{8'h05, 8'h06, 8'h07, 8'h08};
  logic [63:0] gv [4] = '{64'h0, UID, 64'h80, {56'h0, REV}};
  logic [3:0] gl [4] = '{4'h1, 4'h8, 4'h1, 4'h1};
  rch_handler #(.ACK_CYCLES(ACKN), .RESP_CYCLES(RESPN), .UNIQUE_ID(UID),
    .REVISION(REV)) u_dut (.clk(clk), .rst_n(rst_n), .cfgLock(cfgLock),
    .outgoingCommandCode(outCode), .hostSend(hostSend),
    .hostAckService(hostAck), .hostGroupAddr(hostGroupAddr),
    .statusClear(statusClear), .rxValid(rxValid), .rxCode(rxCode),
    .rxPayload(rxPayload), .rxIsAck(rxIsAck), .ackPin(ackPin),
    .txValid(txValid), .txCode(txCode), .txAckService(txAckService),
    .txIsReply(txIsReply), .txPayload(txPayload),
    .txPayloadLen(txPayloadLen), .nodeModeReg(nodeModeReg),
    .wideAddr(wideAddr), .nodeAddr(nodeAddr), .bandDetectEn(bandDetectEn),
    .detectThreshold(thresh), .singleGroup(single), .multiGroup(multi),
    .incomingCommandCode(inCode), .intStatus(intStatus),
    .statusValueChange(statusValueChange));
  rch_peer_model u_peer (.clk(clk), .ackEnable(ackEnable),
    .txValid(txValid), .txAckService(txAckService), .txIsReply(txIsReply),
    .ackPin(ackPin));
  // Clock of 50 ns and a hang limit well past the longest sequence.
  initial forever #25 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      nMismatch++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One received command; returns in the cycle its answer stands.
  task automatic rx(input logic [7:0] code, input logic [15:0] pay);
    @(negedge clk);
    rxValid = 1'b1;
    rxCode = code;
    rxPayload = pay;
    @(negedge clk);
    rxValid = 1'b0;
  endtask
  task automatic send(input logic [7:0] code);
    @(negedge clk);
    hostSend = 1'b1;
    outCode = code;
    @(negedge clk);
    hostSend = 1'b0;
  endtask
  task automatic clear();
    @(negedge clk);
    statusClear = 1'b1;
    @(negedge clk);
    statusClear = 1'b0;
  endtask
  task automatic reply(input logic [63:0] pay, input logic [3:0] len);
    chk("txValid", txValid, 1);
    chk("txIsReply", txIsReply, 1);
    chk("txPayload", txPayload, pay);
    chk("txPayloadLen", txPayloadLen, len);
  endtask
  task automatic summarize();
    if (nMismatch == 0 && nChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    chk("nodeModeReg", nodeModeReg, 0);
    chk("bandDetectEn", bandDetectEn, 1);
    chk("intStatus", intStatus, 0);
    rx(8'h07, 0);
    chk("txValid", txValid, 0);
    rx(8'h05, 0);
    chk("txValid", txValid, 0);
    rx(8'h01, 1);
    reply(0, 1);
    chk("nodeModeReg", nodeModeReg, 8'h80);
    chk("ctrl status", intStatus[4], 1);
    chk("change", statusValueChange, 1);
    chk("inCode", inCode, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      rx(gc[i], 0);
      reply(gv[i], gl[i]);
    end
    rx(8'h03, 1);
    chk("wideAddr", wideAddr, 1);
    rx(8'h04, 16'h1234);
    chk("nodeAddr", nodeAddr, 16'h1234);
    rx(8'h05, 0);
    reply(16'h1234, 2);
    rx(8'h03, 0);
    chk("wideAddr", wideAddr, 0);
    rx(8'h04, 16'hBEEF);
    chk("nodeAddr", nodeAddr, 16'h00EF);
    rx(8'h0C, 1);
    chk("bandDetectEn", bandDetectEn, 0);
    rx(8'h0C, 0);
    chk("bandDetectEn", bandDetectEn, 1);
    rx(8'h0D, 7);
    chk("thresh", thresh, 7);
    rx(8'h0E, 16'hA55A);
    chk("single", single, 8'h5A);
    chk("multi", multi, 8'hA5);
    rx(8'h0F, 0);
    reply(16'hA55A, 2);
    rx(8'h01, 0);
    chk("nodeModeReg", nodeModeReg, 0);
    rx(8'h0F, 0);
    chk("txValid", txValid, 0);
    cfgLock = 1'b1;
    rx(8'h0D, 2);
    reply(1, 1);
    chk("thresh", thresh, 7);
    chk("denied", intStatus[7], 1);
    cfgLock = 1'b0;
    clear();
    rx(8'h1F, 0);
    chk("txValid", txValid, 0);
    chk("intStatus", intStatus, 0);
    rx(8'h45, 0);
    chk("user status", intStatus[6], 1);
    chk("inCode", inCode, 8'h45);
    hostAck = 1'b1;
    rx(8'h09, 0);
    chk("txValid", txValid, 1);
    chk("data status", intStatus[5], 1);
    hostAck = 1'b0;
    rx(8'h0A, 0);
    chk("txValid", txValid, 0);
    clear();
    hostAck = 1'b1;
    send(8'h0A);
    chk("txCode", txCode, 8'h0A);
    chk("txAckService", txAckService, 1);
    repeat (ACKN - 5) @(negedge clk);
    chk("no ack early", intStatus[1], 0);
    repeat (10) @(negedge clk);
    chk("no ack", intStatus[1], 1);
    repeat (RESPN - ACKN) @(negedge clk);
    chk("no response", intStatus[2], 1);
    clear();
    ackEnable = 1'b1;
    send(8'h0A);
    repeat (ACKN + 5) @(negedge clk);
    chk("ack ok", intStatus[0], 1);
    chk("no ack", intStatus[1], 0);
    // far host answers inside the window
    rx(8'h0B, 0);
    chk("response ok", intStatus[3], 1);
    repeat (RESPN) @(negedge clk);
    chk("no response", intStatus[2], 0);
    // An ack packet from the packet layer ends the wait and keeps the code.
    clear();
    ackEnable = 1'b0;
    send(8'h09);
    rxIsAck = 1'b1;
    rx(8'h00, 0);
    rxIsAck = 1'b0;
    chk("ack packet ok", intStatus[0], 1);
    chk("inCode", inCode, 8'h0B);
    hostGroupAddr = 1'b1;
    send(8'h09);
    chk("txAckService", txAckService, 0);
    summarize();
  end
endmodule
bind rch_handler rch_handler_chk u_chk (.clk(clk), .rst_n(rst_n),
  .cfgLock(cfgLock), .hostSend(hostSend),
  .outgoingCommandCode(outgoingCommandCode), .hostGroupAddr(hostGroupAddr),
  .rxValid(rxValid), .rxCode(rxCode), .rxPayload(rxPayload),
  .rxIsAck(rxIsAck), .txValid(txValid), .txCode(txCode),
  .txAckService(txAckService), .txIsReply(txIsReply),
  .txPayload(txPayload), .nodeModeReg(nodeModeReg),
  .detectThreshold(detectThreshold), .incomingCommandCode(incomingCommandCode),
  .intStatus(intStatus), .statusValueChange(statusValueChange));
